// ---- scs_pkg.sv ----
// shared constants and types for the sync control and status port
package scs_pkg;
  // register offsets
  localparam logic [7:0] ADDR_ISR = 8'h00;
  localparam logic [7:0] ADDR_ISR_EN = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_MODE_SEL = 8'h1F;
  // field positions
  localparam int ISR_LOCK_BIT = 0;
  localparam int ISR_HOLD_BIT = 1;
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_HOLD_BIT = 1;
  localparam int ST_FREERUN_BIT = 2;
  localparam int ST_I2C_BIT = 3;
  localparam int MODE_FREERUN_BIT = 0;
  localparam int SPI_RW_BIT = 7;
  // reset values
  localparam logic [7:0] ISR_RST = 8'h00;
  localparam logic [7:0] ISR_EN_RST = 8'h00;
  localparam logic MODE_RST = 1'b0;
  // upper six bits of the i2c bus address; arbitrary value
  localparam logic [5:0] I2C_ADDR_HI = 6'h2A;
  // positions in the synchronised pin vector
  localparam int PIN_MODE = 0;
  localparam int PIN_IFSEL = 1;
  localparam int PIN_SCK = 2;
  localparam int PIN_SDA = 3;
  localparam int PIN_SEL = 4;
  localparam int PIN_W = 5;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_MIN_NS = 300;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // i2c slave states
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_REG, I2C_REG_ACK,
    I2C_WDATA, I2C_WDATA_ACK, I2C_RDATA, I2C_RDATA_ACK, I2C_RD_NEXT
  } scs_i2c_state_e;
endpackage : scs_pkg

// ---- scs_reg_if.sv ----
// register access carrier between the serial engines and the register file
`timescale 1ns/1ps
interface scs_reg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  modport master (output addr, output wdata, output wr, output rd, input rdata);
  modport slave (input addr, input wdata, input wr, input rd, output rdata);
endinterface : scs_reg_if

// ---- scs_regs.sv ----
// register file: mode select, interrupt status, enable and loop status
`timescale 1ns/1ps
module scs_regs (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register access
  scs_reg_if.slave bus,
  // loop status and interface mode
  input wire logic lock_in,
  input wire logic hold_in,
  input wire logic i2c_mode_in,
  // mode pin events
  input wire logic strap_load_in,
  input wire logic pin_change_in,
  input wire logic pin_mode_in,
  // results
  output logic freerun_out,
  output logic int_req_out
);
  import scs_pkg::*;
  logic [7:0] interrupt_service_regs;
  logic [7:0] isr_en;
  logic [7:0] evt;
  logic [7:0] rd_clr;
  logic lock_prev;
  logic hold_prev;
  logic mode_wr;

  // status changes become one-cycle events
  always_comb begin
    evt = 8'h00;
    evt[ISR_LOCK_BIT] = lock_in ^ lock_prev;
    evt[ISR_HOLD_BIT] = hold_in ^ hold_prev;
  end
  assign rd_clr = (bus.rd && bus.addr == ADDR_ISR) ? 8'hFF : 8'h00;
  assign mode_wr = bus.wr && bus.addr == ADDR_MODE_SEL;
  assign int_req_out = |(interrupt_service_regs & isr_en);

  // previous status for change detection
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_prev <= 1'b0;
      hold_prev <= 1'b0;
    end else begin
      lock_prev <= lock_in;
      hold_prev <= hold_in;
    end
  end

  // sticky bits cleared by reading; a new event in the read cycle survives
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interrupt_service_regs <= ISR_RST;
    end else begin
      interrupt_service_regs <= (interrupt_service_regs & ~rd_clr) | evt;
    end
  end

  // interrupt enable
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      isr_en <= ISR_EN_RST;
    end else if (bus.wr && bus.addr == ADDR_ISR_EN) begin
      isr_en <= bus.wdata;
    end
  end

  // loop mode: strap at release, then the latest of pin change or write, a pin change winning over a write in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      freerun_out <= MODE_RST;
    end else if (strap_load_in) begin
      freerun_out <= pin_mode_in;
    end else if (pin_change_in) begin
      freerun_out <= pin_mode_in;
    end else if (mode_wr) begin
      freerun_out <= bus.wdata[MODE_FREERUN_BIT];
    end
  end

  // registered read data; unmapped offsets read zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus.rdata <= 8'h00;
    end else if (bus.rd) begin
      bus.rdata <= 8'h00;
      unique case (bus.addr)
        ADDR_ISR: bus.rdata <= interrupt_service_regs;
        ADDR_ISR_EN: bus.rdata <= isr_en;
        ADDR_STATUS: begin
          bus.rdata[ST_LOCK_BIT] <= lock_in;
          bus.rdata[ST_HOLD_BIT] <= hold_in;
          bus.rdata[ST_FREERUN_BIT] <= freerun_out;
          bus.rdata[ST_I2C_BIT] <= i2c_mode_in;
        end
        ADDR_MODE_SEL: bus.rdata[MODE_FREERUN_BIT] <= freerun_out;
        default: bus.rdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_reg_mode_write: assert property (
    mode_wr && !strap_load_in && !pin_change_in |=> freerun_out == $past(bus.wdata[0]))
    else $error("mode register write not applied");
  chk_isr_read_release: assert property (
    bus.rd && bus.addr == ADDR_ISR && evt == 8'h00 |=> interrupt_service_regs == 8'h00 && !int_req_out)
    else $error("interrupt not released after status read");
  chk_event_sticky: assert property (
    evt[ISR_LOCK_BIT] |=> interrupt_service_regs[ISR_LOCK_BIT])
    else $error("lock change event lost");
  cov_mode_write: cover property (mode_wr);
endmodule : scs_regs

// ---- scs_ctrl_status_port.sv ----
// control and status pins with the shared spi / i2c host port
`timescale 1ns/1ps
module scs_ctrl_status_port (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  // mode and strap pins
  input wire logic MODE_PIN_IN,
  input wire logic IF_SELECT_IN,
  // shared serial pins
  input wire logic SER_CLK_IN,
  output logic SER_CLK_OUT,
  output logic SER_CLK_OE_OUT,
  input wire logic SER_DATA_IN,
  output logic SER_DATA_OUT,
  output logic SER_DATA_OE_OUT,
  output logic SER_SO_OUT,
  input wire logic SELECT_OR_ADDR_BIT0_PIN_IN,
  // loop status from the core
  input wire logic LOOP_FREQ_LOCKED_IN,
  input wire logic LOOP_PHASE_LOCKED_IN,
  input wire logic LOOP_HOLDOVER_IN,
  // indicators
  output logic LOOP_FREERUN_OUT,
  output logic LOCK_OUT,
  output logic HOLD_OUT,
  output logic INT_OUT,
  output logic INT_OE_OUT
);
  import scs_pkg::*;
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync_prev;
  logic taken;
  logic i2c_mode;
  logic strap_load;
  logic pin_change;
  logic freerun;
  logic int_req;
  logic lock_ind;
  logic sck_rise;
  logic sck_fall;
  logic i2c_start;
  logic i2c_stop;
  logic [7:0] spi_byte;
  logic [2:0] spi_cnt;
  logic spi_first;
  logic spi_read;
  logic spi_load_pend;
  logic spi_rd;
  logic spi_wr;
  logic [7:0] spi_ptr;
  logic [7:0] spi_acc;
  logic [7:0] spi_wdata;
  logic [7:0] spi_sh_in;
  logic [7:0] spi_sh_out;
  scs_i2c_state_e i2c_state;
  logic [7:0] i2c_byte;
  logic [2:0] i2c_cnt;
  logic i2c_rw;
  logic i2c_ack_on;
  logic i2c_sda_oe;
  logic i2c_rd;
  logic i2c_wr;
  logic [7:0] i2c_ptr;
  logic [7:0] i2c_acc;
  logic [7:0] i2c_wdata;
  logic [7:0] i2c_sh_in;
  logic [7:0] i2c_sh_out;

  scs_reg_if rif ();

  assign pins = {SELECT_OR_ADDR_BIT0_PIN_IN, SER_DATA_IN, SER_CLK_IN, IF_SELECT_IN, MODE_PIN_IN};

  // two-stage synchronisers without reset so strap levels are seen while reset is low
  always_ff @(posedge SYS_CLK_IN) begin
    sync1 <= pins;
    sync2 <= sync1;
  end

  // previous synchronised levels for edge detection
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sync_prev <= 5'h1F;
    end else begin
      sync_prev <= sync2;
    end
  end

  // the interface select strap is caught in the first cycle after release, then held
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      taken <= 1'b0;
      i2c_mode <= 1'b0;
    end else if (!taken) begin
      taken <= 1'b1;
      i2c_mode <= sync2[PIN_IFSEL];
    end
  end

  // edges of the sampled host clock and i2c start / stop
  assign strap_load = !taken;
  assign pin_change = taken && (sync2[PIN_MODE] ^ sync_prev[PIN_MODE]);
  assign sck_rise = taken && sync2[PIN_SCK] && !sync_prev[PIN_SCK];
  assign sck_fall = taken && !sync2[PIN_SCK] && sync_prev[PIN_SCK];
  assign i2c_start = taken && sync2[PIN_SCK] && sync_prev[PIN_SCK]
                     && !sync2[PIN_SDA] && sync_prev[PIN_SDA];
  assign i2c_stop = taken && sync2[PIN_SCK] && sync_prev[PIN_SCK]
                    && sync2[PIN_SDA] && !sync_prev[PIN_SDA];
  assign spi_byte = {spi_sh_in[6:0], sync2[PIN_SDA]};
  assign i2c_byte = {i2c_sh_in[6:0], sync2[PIN_SDA]};
  assign lock_ind = LOOP_FREQ_LOCKED_IN && LOOP_PHASE_LOCKED_IN
                    && !LOOP_HOLDOVER_IN && !freerun;

  // spi slave: command byte {rw, addr[6:0]}, then data bytes, address advancing
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      spi_cnt <= 3'h0;
      spi_first <= 1'b1;
      spi_read <= 1'b0;
      spi_load_pend <= 1'b0;
      spi_rd <= 1'b0;
      spi_wr <= 1'b0;
      spi_ptr <= 8'h00;
      spi_acc <= 8'h00;
      spi_wdata <= 8'h00;
      spi_sh_in <= 8'h00;
      spi_sh_out <= 8'h00;
    end else begin
      spi_rd <= 1'b0;
      spi_wr <= 1'b0;
      if (i2c_mode || sync2[PIN_SEL]) begin
        spi_cnt <= 3'h0;
        spi_first <= 1'b1;
        spi_load_pend <= 1'b0;
      end else begin
        if (sck_rise) begin
          spi_sh_in <= spi_byte;
          spi_cnt <= spi_cnt + 3'h1;
          if (spi_cnt == 3'h7) begin
            spi_first <= 1'b0;
            if (spi_first) begin
              spi_read <= spi_byte[SPI_RW_BIT];
              spi_rd <= spi_byte[SPI_RW_BIT];
              spi_load_pend <= spi_byte[SPI_RW_BIT];
              spi_acc <= {1'b0, spi_byte[6:0]};
              // reads prefetch the next address, writes land on the addressed register first
              spi_ptr <= {1'b0, spi_byte[6:0]} + {7'h00, spi_byte[SPI_RW_BIT]};
            end else begin
              spi_rd <= spi_read;
              spi_wr <= !spi_read;
              spi_load_pend <= spi_read;
              spi_acc <= spi_ptr;
              spi_wdata <= spi_byte;
              spi_ptr <= spi_ptr + 8'h01;
            end
          end
        end
        // read data change on falling edges, fresh byte loaded after each completed byte
        if (sck_fall) begin
          if (spi_load_pend) begin
            spi_sh_out <= rif.rdata;
            spi_load_pend <= 1'b0;
          end else begin
            spi_sh_out <= {spi_sh_out[6:0], 1'b0};
          end
        end
      end
    end
  end

  // i2c slave: address byte, register pointer byte, then data in or out
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      i2c_state <= I2C_IDLE;
      i2c_cnt <= 3'h0;
      i2c_rw <= 1'b0;
      i2c_ack_on <= 1'b0;
      i2c_sda_oe <= 1'b0;
      i2c_rd <= 1'b0;
      i2c_wr <= 1'b0;
      i2c_ptr <= 8'h00;
      i2c_acc <= 8'h00;
      i2c_wdata <= 8'h00;
      i2c_sh_in <= 8'h00;
      i2c_sh_out <= 8'h00;
    end else begin
      i2c_rd <= 1'b0;
      i2c_wr <= 1'b0;
      if (!i2c_mode) begin
        i2c_state <= I2C_IDLE;
        i2c_sda_oe <= 1'b0;
      end else if (i2c_start) begin
        i2c_state <= I2C_ADDR;
        i2c_cnt <= 3'h0;
        i2c_ack_on <= 1'b0;
        i2c_sda_oe <= 1'b0;
      end else if (i2c_stop) begin
        i2c_state <= I2C_IDLE;
        i2c_sda_oe <= 1'b0;
      end else if (sck_rise) begin
        i2c_sh_in <= i2c_byte;
        i2c_cnt <= i2c_cnt + 3'h1;
        unique case (i2c_state)
          I2C_ADDR: if (i2c_cnt == 3'h7) begin
            if (i2c_byte[7:1] == {I2C_ADDR_HI, sync2[PIN_SEL]}) begin
              i2c_state <= I2C_ADDR_ACK;
              i2c_rw <= i2c_byte[0];
              i2c_rd <= i2c_byte[0];
              i2c_acc <= i2c_ptr;
              if (i2c_byte[0]) i2c_ptr <= i2c_ptr + 8'h01;
            end else begin
              i2c_state <= I2C_IDLE;
            end
          end
          I2C_REG: if (i2c_cnt == 3'h7) begin
            i2c_ptr <= i2c_byte;
            i2c_state <= I2C_REG_ACK;
          end
          I2C_WDATA: if (i2c_cnt == 3'h7) begin
            i2c_wr <= 1'b1;
            i2c_acc <= i2c_ptr;
            i2c_wdata <= i2c_byte;
            i2c_ptr <= i2c_ptr + 8'h01;
            i2c_state <= I2C_WDATA_ACK;
          end
          I2C_RDATA: if (i2c_cnt == 3'h7) i2c_state <= I2C_RDATA_ACK;
          I2C_RDATA_ACK: if (!sync2[PIN_SDA]) begin
            i2c_rd <= 1'b1;
            i2c_acc <= i2c_ptr;
            i2c_ptr <= i2c_ptr + 8'h01;
            i2c_state <= I2C_RD_NEXT;
          end else begin
            i2c_state <= I2C_IDLE;
          end
          default: ;
        endcase
      end else if (sck_fall) begin
        unique case (i2c_state)
          I2C_ADDR_ACK, I2C_REG_ACK, I2C_WDATA_ACK: begin
            if (!i2c_ack_on) begin
              i2c_ack_on <= 1'b1;
              i2c_sda_oe <= 1'b1;
            end else begin
              i2c_ack_on <= 1'b0;
              i2c_cnt <= 3'h0;
              if (i2c_state == I2C_ADDR_ACK && i2c_rw) begin
                i2c_sh_out <= rif.rdata;
                i2c_sda_oe <= !rif.rdata[7];
                i2c_state <= I2C_RDATA;
              end else begin
                i2c_sda_oe <= 1'b0;
                i2c_state <= (i2c_state == I2C_ADDR_ACK) ? I2C_REG : I2C_WDATA;
              end
            end
          end
          I2C_RD_NEXT: begin
            i2c_sh_out <= rif.rdata;
            i2c_sda_oe <= !rif.rdata[7];
            i2c_cnt <= 3'h0;
            i2c_state <= I2C_RDATA;
          end
          I2C_RDATA: begin
            i2c_sh_out <= {i2c_sh_out[6:0], 1'b0};
            i2c_sda_oe <= !i2c_sh_out[6];
          end
          I2C_RDATA_ACK: i2c_sda_oe <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // register access goes to whichever engine the strap selected
  assign rif.addr = i2c_mode ? i2c_acc : spi_acc;
  assign rif.wdata = i2c_mode ? i2c_wdata : spi_wdata;
  assign rif.wr = spi_wr | i2c_wr;
  assign rif.rd = spi_rd | i2c_rd;

  scs_regs u_regs (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .bus(rif.slave),
    .lock_in(lock_ind),
    .hold_in(LOOP_HOLDOVER_IN),
    .i2c_mode_in(i2c_mode),
    .strap_load_in(strap_load),
    .pin_change_in(pin_change),
    .pin_mode_in(sync2[PIN_MODE]),
    .freerun_out(freerun),
    .int_req_out(int_req)
  );

  // pin outputs; the open-drain lines only ever pull low
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      LOCK_OUT <= 1'b0;
      HOLD_OUT <= 1'b0;
      LOOP_FREERUN_OUT <= 1'b0;
      INT_OUT <= 1'b0;
      INT_OE_OUT <= 1'b0;
      SER_CLK_OUT <= 1'b0;
      SER_CLK_OE_OUT <= 1'b0;
      SER_DATA_OUT <= 1'b0;
      SER_DATA_OE_OUT <= 1'b0;
      SER_SO_OUT <= 1'b0;
    end else begin
      LOCK_OUT <= lock_ind;
      HOLD_OUT <= LOOP_HOLDOVER_IN;
      LOOP_FREERUN_OUT <= freerun;
      INT_OUT <= 1'b0;
      INT_OE_OUT <= int_req;
      SER_CLK_OUT <= 1'b0;
      SER_CLK_OE_OUT <= 1'b0;
      SER_DATA_OUT <= 1'b0;
      SER_DATA_OE_OUT <= i2c_sda_oe;
      SER_SO_OUT <= !i2c_mode && !sync2[PIN_SEL] && spi_sh_out[7];
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  chk_strap_mode_load: assert property (strap_load |=> freerun == $past(sync2[PIN_MODE]))
    else $error("default mode not taken from pin at reset release");
  chk_pin_mode_follow: assert property (pin_change |=> freerun == $past(sync2[PIN_MODE]))
    else $error("mode pin change not applied");
  chk_lock_needs_both: assert property (
    !(LOOP_FREQ_LOCKED_IN && LOOP_PHASE_LOCKED_IN) || LOOP_HOLDOVER_IN |=> !LOCK_OUT)
    else $error("lock shown without frequency and phase lock");
  chk_lock_follows: assert property (
    LOOP_FREQ_LOCKED_IN && LOOP_PHASE_LOCKED_IN && !LOOP_HOLDOVER_IN && !freerun |=> LOCK_OUT)
    else $error("lock not shown while locked");
  chk_hold_follows: assert property ($rose(LOOP_HOLDOVER_IN) |=> HOLD_OUT ##1 !LOCK_OUT)
    else $error("holdover not indicated");
  chk_strap_held: assert property (taken && $past(taken) |-> $stable(i2c_mode))
    else $error("interface select changed after reset");
  chk_spi_no_i2c: assert property (!i2c_mode |-> i2c_state == I2C_IDLE)
    else $error("i2c engine active in spi mode");
  chk_sda_quiet_spi: assert property (!i2c_mode |=> !SER_DATA_OE_OUT)
    else $error("data pin driven in spi mode");
  chk_so_quiet_i2c: assert property (i2c_mode |=> !SER_SO_OUT)
    else $error("serial output active in i2c mode");
  chk_cs_deselect: assert property (!i2c_mode && sync2[PIN_SEL] |=> spi_cnt == 3'h0)
    else $error("spi bit count runs while deselected");
  chk_int_open_drain: assert property (!INT_OUT && !SER_CLK_OE_OUT)
    else $error("open-drain line driven high");
  chk_int_follows: assert property (int_req |=> INT_OE_OUT)
    else $error("interrupt not pulled low");

  cov_i2c_ack: cover property (i2c_state == I2C_ADDR_ACK && i2c_ack_on);
  cov_spi_read: cover property (spi_rd && !spi_first);
  cov_int_low: cover property ($rose(INT_OE_OUT));
  cov_freerun_strap: cover property (strap_load && sync2[PIN_MODE]);
endmodule : scs_ctrl_status_port

// ---- scs_host_model.sv ----
// serial host model driving the shared spi / i2c pins of the port
`timescale 1ns/1ps
module scs_host_model (
  // pins towards the device
  output logic sck_out,
  output logic sda_out,
  output logic sel_n_out,
  // pins from the device
  input wire logic so_in,
  input wire logic sda_in
);
  logic [7:0] rd_byte;
  logic [8:0] ln_bits;
  event got;

  // link clock stands still and select is idle outside frames
  initial begin
    sck_out = 1'b0;
    sda_out = 1'b1;
    sel_n_out = 1'b1;
  end

  // one spi frame, mode 0, msb first: command byte then one data byte
  task automatic spi(input logic [7:0] cmd, input logic [7:0] wd);
    logic [15:0] sh;
    sh = {cmd, wd};
    sel_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sda_out = sh[i];
      #160 sck_out = 1'b1;
      // sample late in the high phase, the device answers several clocks after the fall
      #150 rd_byte = {rd_byte[6:0], so_in};
      #10 sck_out = 1'b0;
    end
    #160 sel_n_out = 1'b1;
    sda_out = ~sda_out; // a released line must not keep showing the last bit
    #320;
    if (cmd[7]) begin
      ->got;
    end
  endtask : spi

  // i2c start or repeated start: data falls while the clock line is high
  task automatic i2c_start(input logic asel);
    sel_n_out = asel;
    sda_out = 1'b1;
    #160 sck_out = 1'b1;
    #160 sda_out = 1'b0;
    #160 sck_out = 1'b0;
  endtask : i2c_start

  // eight bits and the ack slot; ln_bits keeps what the line showed at each high phase
  task automatic i2c_bits(input logic [8:0] sh);
    for (int i = 8; i >= 0; i--) begin
      sda_out = sh[i];
      #160 sck_out = 1'b1;
      #150 ln_bits = {ln_bits[7:0], sda_in};
      #10 sck_out = 1'b0;
    end
  endtask : i2c_bits

  // i2c stop: data rises while the clock line is high, then the bus rests
  task automatic i2c_stop;
    sda_out = 1'b0;
    #160 sck_out = 1'b1;
    #160 sda_out = 1'b1;
    #320;
  endtask : i2c_stop

  // i2c address phase: start, address byte, ack slot, stop; rd_byte is 1 on ack
  task automatic i2c_addr(input logic [7:0] ab, input logic asel);
    i2c_start(asel);
    i2c_bits({ab, 1'b1});
    rd_byte = {7'h00, ~ln_bits[0]};
    i2c_stop();
    ->got;
  endtask : i2c_addr

  // i2c register write of one byte; rd_byte holds the three ack bits
  task automatic i2c_wr(input logic [7:0] ab, input logic [7:0] ra, input logic [7:0] wd,
      input logic asel);
    logic [2:0] acks;
    i2c_start(asel);
    i2c_bits({ab, 1'b1});
    acks[2] = ~ln_bits[0];
    i2c_bits({ra, 1'b1});
    acks[1] = ~ln_bits[0];
    i2c_bits({wd, 1'b1});
    acks[0] = ~ln_bits[0];
    i2c_stop();
    rd_byte = {5'h00, acks};
    ->got;
  endtask : i2c_wr

  // i2c register read: pointer write, repeated start, one byte closed by a nack
  task automatic i2c_rd(input logic [7:0] ab, input logic [7:0] ra, input logic asel);
    i2c_start(asel);
    i2c_bits({ab[7:1], 1'b0, 1'b1});
    i2c_bits({ra, 1'b1});
    i2c_start(asel);
    i2c_bits({ab[7:1], 1'b1, 1'b1});
    i2c_bits(9'h1FF);
    rd_byte = ln_bits[8:1];
    i2c_stop();
    ->got;
  endtask : i2c_rd
endmodule : scs_host_model

// ---- tb_sync_ctrl_status_port.sv ----
// self-checking bench for the sync control and status port
`timescale 1ns/1ps
module tb_sync_ctrl_status_port;
  import scs_pkg::*;
  logic clk, rst_n, mode_pin, if_sel, freq_lk, phase_lk, hold_in;
  logic sck_o, sck_oe, sda_o, sda_oe, so, int_o, int_oe, fr, lock, hold;
  logic sck, sda_h, sel_n, el, lk_prev, hd_prev;
  logic [7:0] exp_q[$];
  logic [31:0] xs_state;
  logic [1:0] isr_exp;
  int n_errors;
  int check_count;
  // open-drain lines resolve against their pull-ups
  wire scl_w = sck & ~sck_oe;
  wire sda_w = sda_h & ~sda_oe;

  scs_host_model H (.sck_out(sck), .sda_out(sda_h), .sel_n_out(sel_n), .so_in(so),
    .sda_in(sda_w));
  scs_ctrl_status_port DUT (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .MODE_PIN_IN(mode_pin),
    .IF_SELECT_IN(if_sel), .SER_CLK_IN(scl_w), .SER_CLK_OUT(sck_o), .SER_CLK_OE_OUT(sck_oe),
    .SER_DATA_IN(sda_w), .SER_DATA_OUT(sda_o), .SER_DATA_OE_OUT(sda_oe), .SER_SO_OUT(so),
    .SELECT_OR_ADDR_BIT0_PIN_IN(sel_n), .LOOP_FREQ_LOCKED_IN(freq_lk),
    .LOOP_PHASE_LOCKED_IN(phase_lk), .LOOP_HOLDOVER_IN(hold_in), .LOOP_FREERUN_OUT(fr),
    .LOCK_OUT(lock), .HOLD_OUT(hold), .INT_OUT(int_o), .INT_OE_OUT(int_oe));

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop;
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_byte

  task automatic cmp_pin(input string nm, input logic e, input logic g);
    cmp_byte(nm, {7'h00, e}, {7'h00, g});
  endtask : cmp_pin

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    H.spi({1'b1, a[6:0]}, 8'h00);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    H.spi({1'b0, a[6:0]}, d);
  endtask : wr

  // straps are held steady through reset and its release
  task automatic do_reset(input logic m, input logic i2c);
    mode_pin = m;
    if_sel = i2c;
    rst_n = 1'b0;
    cyc(8);
    rst_n = 1'b1;
    cyc(6);
  endtask : do_reset

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // answers from the host model are matched against the oldest note
  initial forever begin
    @(H.got);
    cmp_byte("serial", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, H.rd_byte);
  end

  // watchdog so that a hang still reaches the verdict
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    $display("MISMATCH watchdog expected done seen hang");
    report_and_stop();
  end

  initial begin
    {freq_lk, phase_lk, hold_in} = 3'b000;
    {lk_prev, hd_prev} = 2'b00;
    xs_state = 32'h0000004D;
    isr_exp = 2'b00;
    n_errors = 0;
    check_count = 0;
    do_reset(1'b0, 1'b0);
    cmp_pin("freerun", 1'b0, fr);
    rd(ADDR_ISR_EN, ISR_EN_RST);
    rd(ADDR_MODE_SEL, 8'h00);
    wr(ADDR_ISR_EN, 8'h03);
    rd(ADDR_ISR_EN, 8'h03);
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00);
    // random loop status stands in for the core paced by the master reference
    repeat (12) begin
      xs_state = xs(xs_state);
      {freq_lk, phase_lk, hold_in} = xs_state[2:0];
      cyc(5);
      el = freq_lk & phase_lk & ~hold_in;
      isr_exp = isr_exp | {hold_in ^ hd_prev, el ^ lk_prev};
      lk_prev = el;
      hd_prev = hold_in;
      cmp_pin("lock", el, lock);
      cmp_pin("hold", hold_in, hold);
      cmp_pin("int_oe", |isr_exp, int_oe);
      cmp_pin("int", 1'b0, int_o);
    end
    rd(ADDR_ISR, {6'h00, isr_exp});
    cmp_pin("int_oe", 1'b0, int_oe);
    // register write selects free-run, which forces lock low
    {freq_lk, phase_lk, hold_in} = 3'b110;
    cyc(5);
    wr(ADDR_MODE_SEL, 8'hFF);
    cyc(8);
    cmp_pin("freerun", 1'b1, fr);
    cmp_pin("lock", 1'b0, lock);
    rd(ADDR_MODE_SEL, 8'h01);
    {freq_lk, phase_lk, hold_in} = 3'b110;
    mode_pin = 1'b1;
    cyc(8);
    mode_pin = 1'b0;
    cyc(8);
    cmp_pin("freerun", 1'b0, fr);
    cmp_pin("lock", 1'b1, lock);
    rd(ADDR_STATUS, 8'(1 << ST_LOCK_BIT));
    mode_pin = 1'b1;
    cyc(8);
    cmp_pin("freerun", 1'b1, fr);
    // strap high: i2c address match acks, a wrong address bit 0 does not
    do_reset(1'b1, 1'b1);
    cmp_pin("freerun", 1'b1, fr);
    exp_q.push_back(8'h01);
    H.i2c_addr({I2C_ADDR_HI, 1'b1, 1'b0}, 1'b1);
    exp_q.push_back(8'h00);
    H.i2c_addr({I2C_ADDR_HI, 1'b1, 1'b0}, 1'b0);
    cmp_pin("so", 1'b0, so);
    // i2c register write clears free-run, then a read of the status register
    exp_q.push_back(8'h07);
    H.i2c_wr({I2C_ADDR_HI, 1'b1, 1'b0}, ADDR_MODE_SEL, 8'h00, 1'b1);
    cyc(8);
    cmp_pin("freerun", 1'b0, fr);
    exp_q.push_back(8'((1 << ST_LOCK_BIT) | (1 << ST_I2C_BIT)));
    H.i2c_rd({I2C_ADDR_HI, 1'b1, 1'b0}, ADDR_STATUS, 1'b1);
    cmp_pin("scl_oe", 1'b0, sck_oe);
    cmp_pin("scl_o", 1'b0, sck_o);
    cmp_pin("sda_o", 1'b0, sda_o);
    cyc(10);
    cmp_byte("pending", 8'h00, 8'(exp_q.size()));
    report_and_stop();
  end
endmodule : tb_sync_ctrl_status_port
